// ==== pps_map.svh ====
// Offsets, reset values, field positions and counts of the port/pointer/trim register bank
`ifndef PPS_MAP_SVH
`define PPS_MAP_SVH

// ==========================================
// Register offsets in the special function register space
`define PPS_OFS_PORT0 8'h80
`define PPS_OFS_STACK_PTR 8'h81
`define PPS_OFS_PTR_LOW 8'h82
`define PPS_OFS_PTR_HIGH 8'h83
`define PPS_OFS_TRIM_HIGH 8'h84
`define PPS_OFS_TRIM_LOW 8'h85
`define PPS_OFS_PORT1 8'h90
`define PPS_OFS_PORT2 8'ha0
`define PPS_OFS_PORT3 8'hb0

// ==========================================
// Reset values
`define PPS_RST_PORT_HI 8'hff
`define PPS_RST_PORT_LO 8'h01
`define PPS_RST_STACK_PTR 8'h07
`define PPS_RST_PTR_BYTE 8'h00
`define PPS_RST_FAST24 1'b0

// ==========================================
// Field positions in the low trim register
`define PPS_TRIM_BIT0_POS 0
`define PPS_FAST24_POS 4

// ==========================================
// Debug pin hold after reset, in low-speed RC clock cycles
`define PPS_DEBUG_HOLD_CYCLES 10'd600

`endif

// ==== pps_pkg.sv ====
// Types shared by the port/pointer/trim register bank
package pps_pkg;

  typedef logic [7:0] pps_byte_t;

  // Debug pin mode after reset, one-hot
  typedef enum logic [1:0] {
    PPS_DBG_QUASI = 2'b01,
    PPS_DBG_INPUT = 2'b10
  } pps_dbg_state_e;

endpackage

// ==== pps_debug_hold.sv ====
// Timer that keeps the debug pins in quasi mode for a fixed count of slow RC cycles
`timescale 1ns/1ps
`include "pps_map.svh"

module pps_debug_hold (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_low_speed_rc_osc_tick,
  output logic o_quasi_mode
);

  pps_pkg::pps_dbg_state_e state_r;
  logic [9:0] count_r;

  // ==========================================
  // Hold state machine, counts slow RC ticks since reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= pps_pkg::PPS_DBG_QUASI;
      count_r <= 10'd0;
    end else if (i_ce) begin
      case (state_r)
        pps_pkg::PPS_DBG_QUASI: begin
          if (i_low_speed_rc_osc_tick) begin
            // Switch on the last of the counted ticks
            if (count_r == `PPS_DEBUG_HOLD_CYCLES - 10'd1) begin
              state_r <= pps_pkg::PPS_DBG_INPUT;
            end
            count_r <= count_r + 10'd1;
          end
        end
        pps_pkg::PPS_DBG_INPUT: begin
          count_r <= count_r;
        end
        default: begin
          state_r <= pps_pkg::PPS_DBG_QUASI;
          count_r <= 10'd0;
        end
      endcase
    end
  end

  // Registered mode flag for the pads
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_quasi_mode <= 1'b1;
    end else if (i_ce) begin
      o_quasi_mode <= (state_r == pps_pkg::PPS_DBG_QUASI) &&
                      !(i_low_speed_rc_osc_tick && count_r == `PPS_DEBUG_HOLD_CYCLES - 10'd1);
    end
  end

endmodule

// ==== pps_sfr_bank.sv ====
// Port latches, stack pointer, data pointers and oscillator trim registers
//
// Overview of operation
// - After reset all pins are inputs with drivers off until software chooses; the debug pins stay quasi with pull-up, the rest float.
// - With reset-pin-disable unprogrammed, port 2 bit 0 always reads zero; code reads zero only while i_reset_pin_disable_cfg is high.
// - Debug pins stay quasi with pull-up 600 slow RC cycles, then become inputs.
// - Trim registers take writes only during the timed-access unlock window.
// - With reset-pin-disable programmed, port 2 bit 0 is input-only, reads pin level; the code reads the pin only while i_reset_pin_disable_cfg is low.
// - Port 3 bit 0 is general purpose only while internal oscillator clocks system.
// - Otherwise port 3 bit 0 is oscillator input; writes ignored, reads zero.
// - Push or call increments stack pointer first, then stores at new address.
// - Stack pointer resets to 07H, so first stacked byte lands at 08H.
// - Low and high bytes form a 16-bit data pointer, each writable, reset zero.
// - Pointer-select bit chooses which of two data pointers the bytes access.
// - Ports bit addressable on all pages; ports 0,1 reset ff, ports 2,3 reset 01.
// - Both trim registers load the factory 16 MHz trim value on reset.
`timescale 1ns/1ps
`include "pps_map.svh"

module pps_sfr_bank (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_sfr_rd,
  input wire logic i_bit_wr,
  input wire logic [7:0] i_bit_addr,
  input wire logic i_bit_wdata,
  input wire logic i_timed_access_unlock,
  input wire logic i_reset_pin_disable_cfg,
  input wire logic i_int_osc_selected,
  input wire logic i_pointer_select_bit,
  input wire logic [31:0] i_pin_drive_en,
  input wire logic [7:0] i_port0_pin,
  input wire logic [7:0] i_port1_pin,
  input wire logic [7:0] i_port2_pin,
  input wire logic [7:0] i_port3_pin,
  input wire logic i_low_speed_rc_osc_tick,
  input wire logic [8:0] i_fast_osc_trim_default,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic i_data_pointer_inc,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output logic [7:0] o_port0_out,
  output logic [7:0] o_port1_out,
  output logic [7:0] o_port2_out,
  output logic [7:0] o_port3_out,
  output logic [7:0] o_port0_oe,
  output logic [7:0] o_port1_oe,
  output logic [7:0] o_port2_oe,
  output logic [7:0] o_port3_oe,
  output logic o_debug_quasi_mode,
  output logic [7:0] o_stack_addr,
  output logic o_stack_we,
  output logic [15:0] o_data_pointer,
  output logic [8:0] o_fast_osc_trim_value,
  output logic o_fast_osc_24mhz_select
);

  // ==========================================
  // Address decode
  logic wr_sp;
  logic wr_dpl;
  logic wr_dph;
  logic wr_trim_hi;
  logic wr_trim_lo;
  logic trim_unlocked;
  logic ext_osc_mode;
  logic p20_readable;

  assign wr_sp = i_sfr_wr && (i_sfr_addr == `PPS_OFS_STACK_PTR);
  assign wr_dpl = i_sfr_wr && (i_sfr_addr == `PPS_OFS_PTR_LOW);
  assign wr_dph = i_sfr_wr && (i_sfr_addr == `PPS_OFS_PTR_HIGH);
  // Trim writes outside the unlock window are dropped silently
  assign trim_unlocked = i_timed_access_unlock;
  assign wr_trim_hi = i_sfr_wr && trim_unlocked && (i_sfr_addr == `PPS_OFS_TRIM_HIGH);
  assign wr_trim_lo = i_sfr_wr && trim_unlocked && (i_sfr_addr == `PPS_OFS_TRIM_LOW);
  // Port 3 bit 0 belongs to the oscillator unless the internal one runs
  assign ext_osc_mode = !i_int_osc_selected;
  // Port 2 bit 0 only carries the pin while the reset-pin-disable config input is low
  assign p20_readable = !i_reset_pin_disable_cfg;

  // ==========================================
  // Port latches and pad controls, one copy per port
  logic [7:0] port_latch [4];
  logic [7:0] port_oe [4];
  logic [7:0] port_pin [4];

  assign port_pin[0] = i_port0_pin;
  assign port_pin[1] = i_port1_pin;
  assign port_pin[2] = i_port2_pin;
  assign port_pin[3] = i_port3_pin;

  function automatic logic [7:0] port_ofs(input int idx);
    case (idx)
      0: port_ofs = `PPS_OFS_PORT0;
      1: port_ofs = `PPS_OFS_PORT1;
      2: port_ofs = `PPS_OFS_PORT2;
      default: port_ofs = `PPS_OFS_PORT3;
    endcase
  endfunction

  genvar gp;
  generate
    for (gp = 0; gp < 4; gp++) begin : g_port
      logic [7:0] latch_r;
      logic [7:0] oe_r;
      logic [7:0] lock_mask;
      logic [7:0] byte_ofs;
      logic byte_wr;
      logic bit_wr;
      logic [2:0] bit_idx;

      assign byte_ofs = port_ofs(gp);
      assign byte_wr = i_sfr_wr && (i_sfr_addr == byte_ofs);
      // Bit addresses of a port share the upper five bits of its byte address
      assign bit_wr = i_bit_wr && (i_bit_addr[7:3] == byte_ofs[7:3]);
      assign bit_idx = i_bit_addr[2:0];
      // Bit 0 of port 3 refuses writes while it is the oscillator input
      assign lock_mask = (gp == 3 && ext_osc_mode) ? 8'h01 : 8'h00;

      // Output latch, reset value depends on the port
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          latch_r <= (gp < 2) ? `PPS_RST_PORT_HI : `PPS_RST_PORT_LO;
        end else if (i_ce) begin
          if (byte_wr) begin
            latch_r <= (i_sfr_wdata & ~lock_mask) | (latch_r & lock_mask);
          end else if (bit_wr && !lock_mask[bit_idx]) begin
            latch_r[bit_idx] <= i_bit_wdata;
          end
        end
      end

      // Drivers stay off after reset until the pin mode selects a driver
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          oe_r <= 8'h00;
        end else if (i_ce) begin
          if (gp == 2) begin
            oe_r <= i_pin_drive_en[gp*8 +: 8] & 8'hfe;
          end else if (gp == 3) begin
            oe_r <= i_pin_drive_en[gp*8 +: 8] & ~lock_mask;
          end else begin
            oe_r <= i_pin_drive_en[gp*8 +: 8];
          end
        end
      end

      assign port_latch[gp] = latch_r;
      assign port_oe[gp] = oe_r;
    end
  endgenerate

  assign o_port0_out = port_latch[0];
  assign o_port1_out = port_latch[1];
  assign o_port2_out = port_latch[2];
  assign o_port3_out = port_latch[3];
  assign o_port0_oe = port_oe[0];
  assign o_port1_oe = port_oe[1];
  assign o_port2_oe = port_oe[2];
  assign o_port3_oe = port_oe[3];

  // ==========================================
  // Debug pin hold after reset
  pps_debug_hold u_debug_hold (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_low_speed_rc_osc_tick(i_low_speed_rc_osc_tick),
    .o_quasi_mode(o_debug_quasi_mode)
  );

  // ==========================================
  // Stack pointer
  logic [7:0] sp_r;
  logic [7:0] sp_inc;

  assign sp_inc = sp_r + 8'h01;

  // Push wins over a register write in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sp_r <= `PPS_RST_STACK_PTR;
    end else if (i_ce) begin
      if (i_push) begin
        sp_r <= sp_inc;
      end else if (i_pop) begin
        sp_r <= sp_r - 8'h01;
      end else if (wr_sp) begin
        sp_r <= i_sfr_wdata;
      end
    end
  end

  // Store strobe points at the already incremented address
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_stack_addr <= 8'h00;
      o_stack_we <= 1'b0;
    end else if (i_ce) begin
      o_stack_we <= i_push;
      if (i_push) begin
        o_stack_addr <= sp_inc;
      end
    end
  end

  // ==========================================
  // Two data pointers, bytes reach only the selected one
  logic [15:0] dptr0_r;
  logic [15:0] second_data_pointer_r;
  logic [15:0] data_pointer_act;

  assign data_pointer_act = i_pointer_select_bit ? second_data_pointer_r : dptr0_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dptr0_r <= {`PPS_RST_PTR_BYTE, `PPS_RST_PTR_BYTE};
    end else if (i_ce && !i_pointer_select_bit) begin
      if (i_data_pointer_inc) begin
        dptr0_r <= dptr0_r + 16'h0001;
      end else if (wr_dpl) begin
        dptr0_r[7:0] <= i_sfr_wdata;
      end else if (wr_dph) begin
        dptr0_r[15:8] <= i_sfr_wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      second_data_pointer_r <= {`PPS_RST_PTR_BYTE, `PPS_RST_PTR_BYTE};
    end else if (i_ce && i_pointer_select_bit) begin
      if (i_data_pointer_inc) begin
        second_data_pointer_r <= second_data_pointer_r + 16'h0001;
      end else if (wr_dpl) begin
        second_data_pointer_r[7:0] <= i_sfr_wdata;
      end else if (wr_dph) begin
        second_data_pointer_r[15:8] <= i_sfr_wdata;
      end
    end
  end

  // Registered copy of the active pointer, one cycle behind the selection
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_data_pointer <= 16'h0000;
    end else if (i_ce) begin
      o_data_pointer <= data_pointer_act;
    end
  end

  // ==========================================
  // Oscillator trim, factory value loaded at reset instead of a constant
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_fast_osc_trim_value <= i_fast_osc_trim_default;
      o_fast_osc_24mhz_select <= `PPS_RST_FAST24;
    end else if (i_ce) begin
      if (wr_trim_hi) begin
        o_fast_osc_trim_value[8:1] <= i_sfr_wdata;
      end
      if (wr_trim_lo) begin
        // Only bits 4 and 0 exist, the rest are dropped
        o_fast_osc_trim_value[0] <= i_sfr_wdata[`PPS_TRIM_BIT0_POS];
        o_fast_osc_24mhz_select <= i_sfr_wdata[`PPS_FAST24_POS];
      end
    end
  end

  // ==========================================
  // Read data, registered; unmapped addresses return zero
  logic [7:0] rd_mux;
  logic rd_hit;
  logic [7:0] trim_lo_view;

  always_comb begin
    trim_lo_view = 8'h00;
    trim_lo_view[`PPS_TRIM_BIT0_POS] = o_fast_osc_trim_value[0];
    trim_lo_view[`PPS_FAST24_POS] = o_fast_osc_24mhz_select;
  end

  // Port reads return pin levels, with the shared bits masked
  always_comb begin
    rd_hit = 1'b1;
    case (i_sfr_addr)
      `PPS_OFS_PORT0: rd_mux = port_pin[0];
      `PPS_OFS_PORT1: rd_mux = port_pin[1];
      `PPS_OFS_PORT2: rd_mux = {port_pin[2][7:1], port_pin[2][0] & p20_readable};
      `PPS_OFS_PORT3: rd_mux = {port_pin[3][7:1], port_pin[3][0] & !ext_osc_mode};
      `PPS_OFS_STACK_PTR: rd_mux = sp_r;
      `PPS_OFS_PTR_LOW: rd_mux = data_pointer_act[7:0];
      `PPS_OFS_PTR_HIGH: rd_mux = data_pointer_act[15:8];
      `PPS_OFS_TRIM_HIGH: rd_mux = o_fast_osc_trim_value[8:1];
      `PPS_OFS_TRIM_LOW: rd_mux = trim_lo_view;
      default: begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
      o_sfr_hit <= 1'b0;
    end else if (i_ce) begin
      if (i_sfr_rd) begin
        o_sfr_rdata <= rd_mux;
        o_sfr_hit <= rd_hit;
      end else begin
        o_sfr_hit <= 1'b0;
      end
    end
  end

endmodule

// ==== pps_sfr_bank_asserts.sv ====
// Checker for the port, pointer and trim register bank
`timescale 1ns/1ps
module pps_sfr_bank_chk (
  input wire logic i_clk, i_rst_n, i_ce, i_sfr_wr, i_sfr_rd, i_push,
  input wire logic i_timed_access_unlock, i_reset_pin_disable_cfg, i_int_osc_selected,
  input wire logic [7:0] i_sfr_addr, i_port2_pin,
  input wire logic [31:0] i_pin_drive_en,
  input wire logic [7:0] o_sfr_rdata, o_port1_oe, o_port2_oe, o_port3_out,
  input wire logic o_sfr_hit, o_stack_we,
  input wire logic [8:0] o_fast_osc_trim_value
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // Bus decode helpers
  logic rd, wr, mapped;
  assign rd = i_ce && i_sfr_rd;
  assign wr = i_ce && i_sfr_wr;
  assign mapped = i_sfr_addr inside {8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h90,
    8'ha0, 8'hb0};
  // ==========================================
  // Properties
  property p_push_we;
    i_ce && i_push |=> o_stack_we;
  endproperty
  property p_we_pulse;
    !(i_ce && i_push) |=> !o_stack_we;
  endproperty
  property p_hit;
    rd && mapped |=> o_sfr_hit;
  endproperty
  property p_unmapped;
    rd && !mapped |=> !o_sfr_hit && o_sfr_rdata == 8'h00;
  endproperty
  property p_p20_zero;
    rd && i_sfr_addr == 8'ha0 && i_reset_pin_disable_cfg |=> o_sfr_rdata[0] == 1'b0;
  endproperty
  property p_p20_pin;
    rd && i_sfr_addr == 8'ha0 && !i_reset_pin_disable_cfg
      |=> o_sfr_rdata[0] == $past(i_port2_pin[0]);
  endproperty
  property p_p20_oe;
    o_port2_oe[0] == 1'b0;
  endproperty
  property p_p30_read;
    rd && i_sfr_addr == 8'hb0 && !i_int_osc_selected |=> o_sfr_rdata[0] == 1'b0;
  endproperty
  property p_p30_wr;
    wr && i_sfr_addr == 8'hb0 && !i_int_osc_selected |=> $stable(o_port3_out[0]);
  endproperty
  property p_trim_lock;
    wr && i_sfr_addr inside {8'h84, 8'h85} && !i_timed_access_unlock
      |=> $stable(o_fast_osc_trim_value);
  endproperty
  property p_oe_follow;
    i_ce |=> o_port1_oe == $past(i_pin_drive_en[15:8]);
  endproperty
  // ==========================================
  // Assertions
  a_push_we: assert property (p_push_we) else $error("no store strobe after push");
  a_we_pulse: assert property (p_we_pulse) else $error("stray store strobe");
  a_hit: assert property (p_hit) else $error("no hit on mapped read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  a_p20_zero: assert property (p_p20_zero) else $error("port2 bit0 not zero");
  a_p20_pin: assert property (p_p20_pin) else $error("port2 bit0 not pin");
  a_p20_oe: assert property (p_p20_oe) else $error("port2 bit0 driven");
  a_p30_read: assert property (p_p30_read) else $error("port3 bit0 not zero");
  a_p30_wr: assert property (p_p30_wr) else $error("port3 bit0 written");
  a_trim_lock: assert property (p_trim_lock) else $error("trim written while locked");
  a_oe_follow: assert property (p_oe_follow) else $error("driver enable lag wrong");
  // Main scenarios reached
  c_push: cover property (i_ce && i_push);
  c_trim_wr: cover property (wr && i_sfr_addr == 8'h84 && i_timed_access_unlock);
  c_p20_rd: cover property (rd && i_sfr_addr == 8'ha0);
endmodule
bind pps_sfr_bank pps_sfr_bank_chk u_chk (.*);

// ==== tb_top.sv ====
// Self-checking bench for the port, pointer and trim register bank
`timescale 1ns/1ps
module tb_top;
  logic i_clk, i_rst_n, i_ce, i_sfr_wr, i_sfr_rd, i_bit_wr, i_bit_wdata, i_push, i_pop;
  logic i_timed_access_unlock, i_reset_pin_disable_cfg, i_int_osc_selected;
  logic i_pointer_select_bit, i_low_speed_rc_osc_tick, i_data_pointer_inc, o_sfr_hit, o_stack_we;
  logic o_debug_quasi_mode, o_fast_osc_24mhz_select;
  logic [7:0] i_sfr_addr, i_sfr_wdata, i_bit_addr, o_sfr_rdata, o_stack_addr;
  logic [7:0] i_port0_pin, i_port1_pin, i_port2_pin, i_port3_pin;
  logic [7:0] o_port0_out, o_port1_out, o_port2_out, o_port3_out;
  logic [7:0] o_port0_oe, o_port1_oe, o_port2_oe, o_port3_oe;
  logic [31:0] i_pin_drive_en;
  logic [15:0] o_data_pointer;
  logic [8:0] i_fast_osc_trim_default, o_fast_osc_trim_value;
  int mismatches, check_count;
  // Rows of address, write data, expected read; port reads give pin levels, port 2 bit 0 reads zero
  logic [23:0] rows [9] = '{24'h815a5a, 24'h823434, 24'h831212, 24'h84a5a5, 24'h85ff11,
    24'h86ff00, 24'h80003d, 24'h90003d, 24'ha0003c};
  pps_sfr_bank DUT (.*);
  always #25 i_clk = ~i_clk;
  // ==========================================
  // Shared tasks
  task automatic step;
    @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Strobes drop with a spare edge so back-to-back calls never re-drive in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1;
    step;
    i_sfr_wr = 0;
    step;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_sfr_addr = a;
    i_sfr_rd = 1;
    step;
    i_sfr_rd = 0;
    chk(o_sfr_hit, a != 8'h86);
    chk(o_sfr_rdata, e);
    step;
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {i_clk, i_rst_n, i_sfr_wr, i_sfr_rd, i_bit_wr, i_bit_wdata, i_push, i_pop} = '0;
    {i_low_speed_rc_osc_tick, i_data_pointer_inc, i_pointer_select_bit, i_timed_access_unlock} = '0;
    {i_sfr_addr, i_sfr_wdata, i_bit_addr, i_pin_drive_en} = '0;
    {i_ce, i_reset_pin_disable_cfg, i_int_osc_selected} = 3'b111;
    {i_port0_pin, i_port1_pin, i_port2_pin, i_port3_pin} = {4{8'h3d}};
    i_fast_osc_trim_default = 9'h15b;
    repeat (6) step;
    i_rst_n = 1;
    chk({o_port0_out, o_port1_out}, 16'hffff);
    chk({o_port2_out, o_port3_out}, 16'h0101);
    chk({o_port0_oe, o_port1_oe} | {o_port2_oe, o_port3_oe}, 16'h0000);
    chk(o_data_pointer, 16'h0000);
    chk(o_fast_osc_trim_value, 9'h15b);
    chk({o_fast_osc_24mhz_select, o_debug_quasi_mode, o_stack_we}, 3'b010);
    i_push = 1;
    step;
    i_push = 0;
    chk({o_stack_we, o_stack_addr}, 9'h108);
    step;
    rd(8'h81, 8'h08);
    rd(8'h84, 8'had);
    rd(8'h85, 8'h01);
    i_timed_access_unlock = 1;
    foreach (rows[k]) begin
      wr(rows[k][23:16], rows[k][15:8]);
      rd(rows[k][23:16], rows[k][7:0]);
    end
    chk({o_fast_osc_24mhz_select, o_fast_osc_trim_value}, 10'h34b);
    i_bit_addr = 8'h93;
    i_bit_wdata = 1;
    i_bit_wr = 1;
    step;
    i_bit_wr = 0;
    chk(o_port1_out, 8'h08);
    i_timed_access_unlock = 0;
    wr(8'h84, 8'h00);
    rd(8'h84, 8'ha5);
    i_int_osc_selected = 0;
    wr(8'hb0, 8'hf0);
    chk(o_port3_out, 8'hf1);
    rd(8'hb0, 8'h3c);
    i_reset_pin_disable_cfg = 0;
    rd(8'ha0, 8'h3d);
    i_int_osc_selected = 1;
    i_pin_drive_en = 32'h01ffa501;
    step;
    step;
    chk({o_port3_oe, o_port2_oe}, 16'h01fe);
    chk({o_port1_oe, o_port0_oe}, 16'ha501);
    i_pointer_select_bit = 1;
    wr(8'h82, 8'h77);
    chk(o_data_pointer, 16'h0077);
    i_pointer_select_bit = 0;
    step;
    step;
    chk(o_data_pointer, 16'h1234);
    i_data_pointer_inc = 1;
    step;
    i_data_pointer_inc = 0;
    step;
    chk(o_data_pointer, 16'h1235);
    // Clock enable low freezes latches and the stack pointer
    i_ce = 0;
    i_push = 1;
    wr(8'h80, 8'h55);
    i_push = 0;
    i_ce = 1;
    chk(o_stack_we, 1'b0);
    chk(o_port0_out, 8'h00);
    rd(8'h81, 8'h5a);
    i_pop = 1;
    step;
    i_pop = 0;
    rd(8'h81, 8'h59);
    i_rst_n = 0;
    repeat (6) step;
    i_rst_n = 1;
    chk({o_port3_out, o_port2_out}, 16'h0101);
    chk({o_port0_oe, o_port3_oe}, 16'h0000);
    chk(o_fast_osc_trim_value, 9'h15b);
    chk(o_data_pointer, 16'h0000);
    rd(8'h81, 8'h07);
    i_low_speed_rc_osc_tick = 1;
    repeat (599) step;
    chk(o_debug_quasi_mode, 1'b1);
    step;
    chk(o_debug_quasi_mode, 1'b0);
    report_and_stop;
  end
  // Hang guard, well beyond the roughly 700 cycles of traffic
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end
endmodule
